// ===== irq_mode_clear_ctrl.sv
// per-source mode, routing and pending-clear logic for interrupt sources 59 to 63
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - with DMA select 0 the level field is the processor priority, 000 disabling and 001-111 giving levels 1-7.
// - with DMA select 1 a request starts the DMA controller instead of interrupting the processor.
// - with DMA select 1 level codes 000-011 pick DMA channels 0-3 and codes 100-111 are invalid.
// - source 59 has the same DMA select capability as sources 60 to 63.
// - writing a source's six-bit vector index to the clear register clears that source's pending request.
module irq_mode_clear_ctrl (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [irq_mode_pkg::N_SRC-1:0] i_src_req,
	output logic o_irq_req,
	output logic [2:0] o_irq_level,
	output logic [5:0] o_irq_src_num,
	output logic [irq_mode_pkg::N_DMA_CH-1:0] o_dma_start,
	output logic [2*irq_mode_pkg::N_SRC-1:0] o_detect_mode
);
	import irq_mode_pkg::*;

	logic [1:0] mode_q [N_SRC];
	logic [N_SRC-1:0] dma_sel_q;
	logic [2:0] lvl_q [N_SRC];
	logic [N_SRC-1:0] pend_q;
	logic [N_SRC-1:0] en_cpu;
	logic [N_SRC-1:0] dma_ok;
	logic [N_SRC-1:0] clr_hit;
	logic [N_DMA_CH-1:0] dma_start_d;
	logic [31:0] rdata_d;
	logic [2:0] best_lvl;
	logic [5:0] best_num;
	logic clr_wr;

	assign clr_wr = i_wr && (i_addr == REQ_CLEAR_ADDR);

	genvar g;
	generate
		for (g = 0; g < N_SRC; g++) begin : g_src
			localparam logic [31:0] REG_ADDR = (g == 0) ? MODE_CTRL_59_ADDR : MODE_CTRL_60_63_ADDR;
			localparam int LANE = (g == 0) ? SRC59_LANE : g - 1;
			localparam logic [5:0] SRC_NUM = SRC_FIRST_NUM + 6'(g);
			logic wr_hit;
			assign wr_hit = i_wr && (i_addr == REG_ADDR);
			// fields start cleared, source disabled
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					mode_q[g] <= MODE_RESET;
					dma_sel_q[g] <= 1'b0;
					lvl_q[g] <= LVL_RESET;
				end else if (wr_hit) begin
					mode_q[g] <= i_wdata[8*LANE+FLD_MODE_LSB +: 2];
					dma_sel_q[g] <= i_wdata[8*LANE+FLD_DMA_BIT];
					lvl_q[g] <= i_wdata[8*LANE+FLD_LVL_LSB +: 3];
				end
			end
			assign en_cpu[g] = !dma_sel_q[g] && (lvl_q[g] != LVL_OFF);
			assign dma_ok[g] = dma_sel_q[g] && (lvl_q[g] <= DMA_CH_LAST);
			// only the low six bits of the clear register carry the index
			assign clr_hit[g] = clr_wr && (i_wdata[CLR_IDX_MSB:0] == SRC_NUM);
			// a new request wins over a clear in the same cycle
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					pend_q[g] <= 1'b0;
				end else if (i_src_req[g] && en_cpu[g]) begin
					pend_q[g] <= 1'b1;
				end else if (clr_hit[g]) begin
					pend_q[g] <= 1'b0;
				end
			end
			assign o_detect_mode[2*g +: 2] = mode_q[g];
		end
	endgenerate

	// dma start: one pulse on the chosen channel per request
	always_comb begin
		dma_start_d = '0;
		for (int i = 0; i < N_SRC; i++) begin
			if (i_src_req[i] && dma_ok[i]) begin
				dma_start_d[lvl_q[i][1:0]] = 1'b1;
			end
		end
	end

	// highest level wins, lower source number on a tie
	always_comb begin
		best_lvl = LVL_OFF;
		best_num = '0;
		for (int i = 0; i < N_SRC; i++) begin
			if (pend_q[i] && en_cpu[i] && (lvl_q[i] > best_lvl)) begin
				best_lvl = lvl_q[i];
				best_num = SRC_FIRST_NUM + 6'(i);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_dma_start <= '0;
		end else begin
			o_dma_start <= dma_start_d;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq_req <= 1'b0;
			o_irq_level <= LVL_OFF;
			o_irq_src_num <= '0;
		end else begin
			o_irq_req <= (best_lvl != LVL_OFF);
			o_irq_level <= best_lvl;
			o_irq_src_num <= best_num;
		end
	end

	always_comb begin
		rdata_d = '0;
		unique case (i_addr)
			MODE_CTRL_59_ADDR: begin
				rdata_d[8*SRC59_LANE +: 6] = {mode_q[0], dma_sel_q[0], lvl_q[0]};
			end
			MODE_CTRL_60_63_ADDR: begin
				for (int i = 1; i < N_SRC; i++) begin
					rdata_d[8*(i-1) +: 6] = {mode_q[i], dma_sel_q[i], lvl_q[i]};
				end
			end
			PEND_STATUS_ADDR: begin
				rdata_d[N_SRC-1:0] = pend_q;
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= '0;
		end
	end

	logic [N_SRC-1:0] blk_req;
	logic [N_SRC-1:0] clr_only;
	logic [N_SRC-1:0] set_req;
	logic [N_SRC-1:0] dma_go;
	logic [N_SRC-1:0] dma_blk;
	assign blk_req = i_src_req & ~en_cpu & ~pend_q;
	assign clr_only = clr_hit & ~(i_src_req & en_cpu);
	assign set_req = i_src_req & en_cpu;
	assign dma_go = i_src_req & dma_ok;
	assign dma_blk = i_src_req & dma_sel_q & ~pend_q;

	property p_blocked_no_pend;
		@(posedge i_clk) disable iff (!i_reset_n) (blk_req != '0) |=> ((pend_q & $past(blk_req)) == '0);
	endproperty
	a_blocked_no_pend: assert property (p_blocked_no_pend) else $error("disabled or dma source became pending");

	property p_irq_has_level;
		@(posedge i_clk) disable iff (!i_reset_n) o_irq_req |-> (o_irq_level != LVL_OFF) && (o_irq_src_num >= SRC_FIRST_NUM);
	endproperty
	a_irq_has_level: assert property (p_irq_has_level) else $error("irq raised without a level");

	property p_set_to_irq;
		@(posedge i_clk) disable iff (!i_reset_n) (set_req != '0) && !i_wr |-> ##2 o_irq_req;
	endproperty
	a_set_to_irq: assert property (p_set_to_irq) else $error("enabled request did not reach processor");

	property p_dma_not_cpu;
		@(posedge i_clk) disable iff (!i_reset_n) (dma_blk != '0) |=> ((pend_q & $past(dma_blk)) == '0);
	endproperty
	a_dma_not_cpu: assert property (p_dma_not_cpu) else $error("dma-routed request became processor pending");

	property p_dma_channel;
		@(posedge i_clk) disable iff (!i_reset_n) (i_src_req[1] && dma_ok[1]) |=> o_dma_start[$past(lvl_q[1][1:0])];
	endproperty
	a_dma_channel: assert property (p_dma_channel) else $error("dma channel not started");

	property p_dma_invalid;
		@(posedge i_clk) disable iff (!i_reset_n) ((i_src_req & dma_ok) == '0) |=> (o_dma_start == '0);
	endproperty
	a_dma_invalid: assert property (p_dma_invalid) else $error("dma start without a valid request");

	property p_src59_dma;
		@(posedge i_clk) disable iff (!i_reset_n) dma_go[0] |=> o_dma_start[$past(lvl_q[0][1:0])] ##1
			(!o_dma_start[$past(lvl_q[0][1:0], 2)] || ($past(dma_go) != '0));
	endproperty
	a_src59_dma: assert property (p_src59_dma) else $error("source 59 dma start wrong");

	property p_clear;
		@(posedge i_clk) disable iff (!i_reset_n) (clr_only != '0) |=> ((pend_q & $past(clr_only)) == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("clear write did not clear pending");

	property p_set_wins;
		@(posedge i_clk) disable iff (!i_reset_n) (set_req != '0) |=> ((pend_q & $past(set_req)) == $past(set_req));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("request lost against clear");

	property p_reset_clean;
		@(posedge i_clk) $rose(i_reset_n) |-> !o_irq_req && (o_dma_start == '0) && (pend_q == '0);
	endproperty
	a_reset_clean: assert property (p_reset_clean) else $error("state not clear after reset");

	c_irq: cover property (@(posedge i_clk) disable iff (!i_reset_n) (set_req != '0) ##2 o_irq_req);
	c_dma: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_dma_start != '0);
	c_src59_dma: cover property (@(posedge i_clk) disable iff (!i_reset_n) dma_go[0] ##1 (o_dma_start != '0));
	c_clear: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_irq_req ##[1:20] (clr_only != '0));
endmodule // irq_mode_clear_ctrl

// ===== irq_mode_pkg.sv
// constants for the interrupt mode and request-clear block
package irq_mode_pkg;
	localparam int N_SRC = 5;
	localparam logic [5:0] SRC_FIRST_NUM = 6'h3B;
	localparam logic [31:0] MODE_CTRL_59_ADDR = 32'hFFFFE038;
	localparam logic [31:0] MODE_CTRL_60_63_ADDR = 32'hFFFFE03C;
	localparam logic [31:0] REQ_CLEAR_ADDR = 32'hFFFFE060;
	localparam logic [31:0] PEND_STATUS_ADDR = 32'hFFFFE068;
	localparam int SRC59_LANE = 3;
	localparam int FLD_LVL_LSB = 0;
	localparam int FLD_DMA_BIT = 3;
	localparam int FLD_MODE_LSB = 4;
	localparam int CLR_IDX_MSB = 5;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [2:0] LVL_RESET = 3'h0;
	localparam logic [2:0] LVL_OFF = 3'h0;
	localparam logic [2:0] DMA_CH_LAST = 3'h3;
	localparam int N_DMA_CH = 4;
endpackage

// ===== irq_partner_model.sv
// stand-in for the processor core and dma controller on the block's outputs
`timescale 1ns/1ps
module irq_partner_model (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_irq_req,
	input wire logic [5:0] i_irq_src_num,
	input wire logic [3:0] i_dma_start,
	output logic [5:0] o_vector_q,
	output logic [7:0] o_dma_count_q
);
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_vector_q <= 6'h00;
		end else if (i_irq_req) begin
			o_vector_q <= i_irq_src_num;
		end
	end
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_dma_count_q <= 8'h00;
		end else begin
			o_dma_count_q <= o_dma_count_q + 8'($countones(i_dma_start));
		end
	end
endmodule // irq_partner_model

// ===== tb_irq_mode_clear_ctrl.sv
// self-checking bench for the mode, routing and clear block
`timescale 1ns/1ps
module tb_irq_mode_clear_ctrl;
	import irq_mode_pkg::*;
	logic i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0;
	logic [31:0] i_addr = 32'h0, i_wdata = 32'h0;
	logic [4:0] i_src_req = 5'h00;
	logic [31:0] o_rdata;
	logic o_irq_req;
	logic [2:0] o_irq_level;
	logic [5:0] o_irq_src_num, vec;
	logic [3:0] o_dma_start;
	logic [9:0] o_detect_mode;
	logic [7:0] dma_cnt;
	int n_fail = 0, checked = 0;
	logic [3:0] dma_exp [5] = '{4'h2, 4'h1, 4'h8, 4'h0, 4'h0};
	irq_mode_clear_ctrl dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_src_req(i_src_req), .o_irq_req(o_irq_req),
		.o_irq_level(o_irq_level), .o_irq_src_num(o_irq_src_num), .o_dma_start(o_dma_start),
		.o_detect_mode(o_detect_mode));
	irq_partner_model core (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_irq_req(o_irq_req),
		.i_irq_src_num(o_irq_src_num), .i_dma_start(o_dma_start), .o_vector_q(vec), .o_dma_count_q(dma_cnt));
	initial begin
		forever #12.5 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_clk) i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
		@(posedge i_clk) i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask
	task automatic pulse(input logic [4:0] m);
		@(posedge i_clk) i_src_req <= m;
		@(posedge i_clk) i_src_req <= 5'h00;
		#1;
	endtask
	task automatic irq_is(input logic [9:0] exp);
		@(posedge i_clk);
		#1 chk({22'h0, o_irq_req, o_irq_level, o_irq_src_num}, {22'h0, exp});
	endtask
	// clear the request the core last saw, junk in the ignored upper bits
	task automatic clr_seen();
		@(posedge i_clk);
		#1 wr(REQ_CLEAR_ADDR, {26'h3FFFFFF, vec});
	endtask
	task automatic complete_run();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge i_clk);
		n_fail++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd(MODE_CTRL_60_63_ADDR, 32'h0);
		rd(MODE_CTRL_59_ADDR, 32'h0);
		rd(REQ_CLEAR_ADDR, 32'h0);
		rd(32'hFFFFE040, 32'h0);
		chk(o_detect_mode, 10'h000);
		$display("reset test done");
		wr(MODE_CTRL_60_63_ADDR, 32'h20272725);
		rd(MODE_CTRL_60_63_ADDR, 32'h20272725);
		chk(o_detect_mode, 10'h2A8);
		pulse(5'h1E);
		chk(o_dma_start, 4'h0);
		irq_is({1'b1, 3'h7, 6'h3D});
		rd(PEND_STATUS_ADDR, 32'h0000000E);
		clr_seen();
		irq_is({1'b1, 3'h7, 6'h3E});
		clr_seen();
		irq_is({1'b1, 3'h5, 6'h3C});
		wr(MODE_CTRL_60_63_ADDR, 32'h20272720);
		irq_is(10'h0);
		wr(REQ_CLEAR_ADDR, 32'h0000003C);
		wr(MODE_CTRL_60_63_ADDR, 32'h20272725);
		irq_is(10'h0);
		rd(PEND_STATUS_ADDR, 32'h0);
		$display("priority test done");
		wr(MODE_CTRL_59_ADDR, 32'h39000000);
		wr(MODE_CTRL_60_63_ADDR, 32'h202C2B28);
		rd(MODE_CTRL_59_ADDR, 32'h39000000);
		chk(o_detect_mode, 10'h2AB);
		for (int i = 0; i < N_SRC; i++) begin
			pulse(5'(1 << i));
			chk(o_dma_start, dma_exp[i]);
			irq_is(10'h0);
		end
		chk(dma_cnt, 8'h03);
		rd(PEND_STATUS_ADDR, 32'h0);
		$display("dma test done");
		complete_run();
	end
endmodule // tb_irq_mode_clear_ctrl
